// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb
  import pss_pkg::*;
;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic power_strobe = 1'b0;
  pss_bus_t bus = '0;
  pss_power_t [2:0] phase_power = '0;
  logic [15:0] rdata, m_cfg, m_comp, m_rd, cfgv;
  logic first_pulse_out, second_pulse_out, third_pulse_out;
  logic [2:0] m_p, sel;
  logic [19:0] m_acc [3];
  logic [20:0] nsum;
  logic [95:0] rnd;
  integer seed = 32'h0fd6;
  integer num_errors = 0;
  integer samples_checked = 0;
  integer cyc = 0;

  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end

  pss_pulse_source DUT (.sys_clk(sys_clk), .resetn(resetn), .bus(bus), .rdata(rdata),
    .phase_power(phase_power), .power_strobe(power_strobe),
    .first_pulse_out(first_pulse_out), .second_pulse_out(second_pulse_out),
    .third_pulse_out(third_pulse_out));

  // ------------------------------
  // reference model
  // ------------------------------
  function automatic logic [15:0] fsum(input logic [2:0] s, input logic [2:0] m,
                                       input pss_power_t [2:0] p);
    logic [17:0] a;
    a = '0;
    for (int i = 0; i < 3; i++)
      if (m[i])
        case (s)
          3'h0: a = a + p[i].tot_act;
          3'h1: a = a + p[i].tot_react;
          3'h2: a = a + p[i].apparent;
          3'h3: a = a + p[i].fund_act;
          default: a = a + p[i].fund_react;
        endcase
    return (a > 18'h0ffff) ? 16'hffff : a[15:0];
  endfunction

  // sees inputs before this edge's updates land, like the design
  always @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      m_cfg <= 16'h0088;
      m_comp <= 16'h01ff;
      m_p <= '0;
      m_rd <= '0;
      for (int k = 0; k < 3; k++) m_acc[k] <= '0;
    end
    else
    begin
      if (bus.wr && bus.addr == 4'h0) m_cfg <= bus.wdata;
      if (bus.wr && bus.addr == 4'h1) m_comp <= bus.wdata;
      m_rd <= !bus.rd ? 16'h0 : bus.addr == 4'h0 ? m_cfg : bus.addr == 4'h1 ? m_comp :
              bus.addr == 4'h2 ? {13'h0, m_p} : 16'h0;
      for (int k = 0; k < 3; k++)
      begin
        sel = m_cfg[3*k +: 3];
        nsum = {1'b0, m_acc[k]} + {5'h0, fsum(sel, m_comp[3*k +: 3], phase_power)};
        if (sel > 3'h4)
        begin
          m_acc[k] <= '0;
          m_p[k] <= 1'b0;
        end
        else if (power_strobe)
        begin
          m_acc[k] <= nsum[19:0];
          if (nsum[20]) m_p[k] <= ~m_p[k];
        end
      end
    end

  // ------------------------------
  // stimulus and checks
  // ------------------------------
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (!ok)
    begin
      num_errors++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask

  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic bus_op(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge sys_clk);
    bus <= '0;
  endtask

  always @(negedge sys_clk)
    if (resetn)
    begin
      chk(rdata === m_rd, "read data");
      chk({third_pulse_out, second_pulse_out, first_pulse_out} === m_p, "pulses");
    end

  always @(posedge sys_clk)
  begin
    power_strobe <= ($random(seed) % 4) != 0;
    for (int i = 0; i < 3; i++)
    begin
      rnd = {$random(seed), $random(seed), $random(seed)};
      phase_power[i] <= rnd[79:0];
    end
    cyc++;
    if (cyc == 4000)
    begin
      num_errors++;
      complete_run;
    end
  end

  initial
  begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int a = 0; a < 4; a++) bus_op(1'b0, a[3:0], '0);
    bus_op(1'b0, 4'hf, '0);
    for (int t = 0; t < 24; t++)
    begin
      // first eight passes sweep every code on all three outputs
      cfgv = (t < 8) ? {7'h0, t[2:0], t[2:0], t[2:0]} : 16'($random(seed));
      bus_op(1'b1, 4'h0, cfgv);
      bus_op(1'b1, 4'h1, (t == 3) ? 16'h0 : 16'($random(seed)));
      bus_op(1'b0, 4'h0, '0);
      repeat (48) @(posedge sys_clk);
      $display("test %0d done", t);
    end
    complete_run;
  end
endmodule
`default_nettype wire

// *** verilog/pss_consts.svh ***
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH
// register indices (no offsets are printed, so these are of our own)
`define PSS_ADDR_CONFIG 4'h0
`define PSS_ADDR_COMP 4'h1
`define PSS_ADDR_STATUS 4'h2
// config field positions
`define PSS_SEL1_LSB 0
`define PSS_SEL2_LSB 3
`define PSS_SEL3_LSB 6
`define PSS_CFG_RESET 16'h0088
// compensation mode phase masks
`define PSS_MASK1_LSB 0
`define PSS_MASK2_LSB 3
`define PSS_MASK3_LSB 6
`define PSS_COMP_RESET 16'h01ff
`define PSS_MASK_ALL 3'h7
`define PSS_ACC_ZERO 20'h00000
`define PSS_RD_ZERO 16'h0000
`endif

// *** verilog/pss_pkg.sv ***
`default_nettype none
package pss_pkg;
  typedef enum logic [2:0] {
    PSS_SRC_TOT_ACT = 3'h0,
    PSS_SRC_TOT_REACT = 3'h1,
    PSS_SRC_APPARENT = 3'h2,
    PSS_SRC_FUND_ACT = 3'h3,
    PSS_SRC_FUND_REACT = 3'h4
  } pss_src_t;
  // one phase sample of every power quantity
  typedef struct packed {
    logic [15:0] tot_act;
    logic [15:0] tot_react;
    logic [15:0] apparent;
    logic [15:0] fund_act;
    logic [15:0] fund_react;
  } pss_power_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pss_bus_t;
  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] comp;
    logic [15:0] rdata;
    logic [2:0][19:0] acc;
    logic [2:0] pulse;
  } pss_state_t;
endpackage
`default_nettype wire

// *** verilog/pss_pulse_source.sv ***
// ------------------------------
// Overview of operation
// ------------------------------
// Overview of operation
// - first select 010 apparent, 100 fund reactive
// - second select bits 5:3, default 001
// - second code 001 sums total reactive
// - second code 010 sums apparent
// - second code 100 sums fundamental reactive
// - second reserved codes stop second output
// - third select bits 8:6, default 010
// - only masked phases add to sum
// - first reserved codes stop first output
`timescale 1ns/1ps
`default_nettype none
`include "pss_consts.svh"
module pss_pulse_source
  import pss_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // register port
  input wire pss_bus_t bus,
  output logic [15:0] rdata,
  // per-phase powers, one sample per power_strobe
  input wire pss_power_t [2:0] phase_power,
  input wire logic power_strobe,
  // pulse outputs
  output logic first_pulse_out,
  output logic second_pulse_out,
  output logic third_pulse_out
);
  // ------------------------------
  // state
  // ------------------------------
  pss_state_t st_ff;
  pss_state_t nxt_st;
  logic [2:0][2:0] sel;
  logic [2:0][2:0] mask;
  logic [2:0][15:0] sum;
  logic [2:0] active;
  logic [2:0][20:0] acc_add;

  assign sel[0] = st_ff.cfg[`PSS_SEL1_LSB +: 3];
  assign sel[1] = st_ff.cfg[`PSS_SEL2_LSB +: 3];
  assign sel[2] = st_ff.cfg[`PSS_SEL3_LSB +: 3];
  assign mask[0] = st_ff.comp[`PSS_MASK1_LSB +: 3];
  assign mask[1] = st_ff.comp[`PSS_MASK2_LSB +: 3];
  assign mask[2] = st_ff.comp[`PSS_MASK3_LSB +: 3];

  // ------------------------------
  // per-output source mux and sum
  // ------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_out
      always_comb
      begin
        logic [17:0] s;
        logic [15:0] v;
        s = 18'h00000;
        v = 16'h0000;
        active[gi] = 1'b1;
        for (int p = 0; p < 3; p++)
        begin
          case (sel[gi])
            PSS_SRC_TOT_ACT: v = phase_power[p].tot_act;
            PSS_SRC_TOT_REACT: v = phase_power[p].tot_react;
            PSS_SRC_APPARENT: v = phase_power[p].apparent;
            PSS_SRC_FUND_ACT: v = phase_power[p].fund_act;
            PSS_SRC_FUND_REACT: v = phase_power[p].fund_react;
            default: v = 16'h0000;
          endcase
          if (mask[gi][p])
          begin
            s = s + {2'h0, v};
          end
        end
        // reserved codes park the output low
        if (sel[gi] > PSS_SRC_FUND_REACT)
        begin
          active[gi] = 1'b0;
        end
        // saturate to the pulse accumulator's increment width
        sum[gi] = (s[17:16] != 2'h0) ? 16'hffff : s[15:0];
        acc_add[gi] = {1'b0, st_ff.acc[gi]} + {5'h00, sum[gi]};
      end
    end
  endgenerate

  // ------------------------------
  // next state
  // ------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rdata = `PSS_RD_ZERO;
    if (bus.wr && bus.addr == `PSS_ADDR_CONFIG)
    begin
      nxt_st.cfg = bus.wdata;
    end
    if (bus.wr && bus.addr == `PSS_ADDR_COMP)
    begin
      nxt_st.comp = bus.wdata;
    end
    if (bus.rd)
    begin
      case (bus.addr)
        `PSS_ADDR_CONFIG: nxt_st.rdata = st_ff.cfg;
        `PSS_ADDR_COMP: nxt_st.rdata = st_ff.comp;
        `PSS_ADDR_STATUS: nxt_st.rdata = {13'h0000, st_ff.pulse};
        default: nxt_st.rdata = `PSS_RD_ZERO;
      endcase
    end
    for (int i = 0; i < 3; i++)
    begin
      // only the output whose field is inactive is affected
      if (!active[i])
      begin
        nxt_st.acc[i] = `PSS_ACC_ZERO;
        nxt_st.pulse[i] = 1'b0;
      end
      else if (power_strobe)
      begin
        // accumulator carry is the output rate; toggle halves it to a square wave
        nxt_st.acc[i] = acc_add[i][19:0];
        nxt_st.pulse[i] = st_ff.pulse[i] ^ acc_add[i][20];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_ff.cfg <= `PSS_CFG_RESET;
      st_ff.comp <= `PSS_COMP_RESET;
      st_ff.rdata <= `PSS_RD_ZERO;
      st_ff.acc <= '0;
      st_ff.pulse <= 3'h0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rdata;
  assign first_pulse_out = st_ff.pulse[0];
  assign second_pulse_out = st_ff.pulse[1];
  assign third_pulse_out = st_ff.pulse[2];

  // ------------------------------
  // checks
  // ------------------------------
  a_second_reserved_low: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sel[1] > 3'h4) |=> !second_pulse_out)
    else $error("second output active on reserved code");
  a_first_reserved_low: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sel[0] > 3'h4) |=> !first_pulse_out)
    else $error("first output active on reserved code");
  a_second_default_sel: assert property (@(posedge sys_clk)
    $rose(resetn) |-> sel[1] == 3'h1)
    else $error("second select default wrong");
  a_third_default_sel: assert property (@(posedge sys_clk)
    $rose(resetn) |-> sel[2] == 3'h2)
    else $error("third select default wrong");
  a_masked_sum_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mask[1] == 3'h0) |-> sum[1] == 16'h0000)
    else $error("unselected phases contribute");
  a_second_reactive: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sel[1] == 3'h1 && mask[1] == 3'h1) |-> sum[1] == phase_power[0].tot_react)
    else $error("second reactive source wrong");
  a_second_apparent: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sel[1] == 3'h2 && mask[1] == 3'h2) |-> sum[1] == phase_power[1].apparent)
    else $error("second apparent source wrong");
  a_second_fund_react: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sel[1] == 3'h4 && mask[1] == 3'h4) |-> sum[1] == phase_power[2].fund_react)
    else $error("second fundamental reactive source wrong");
  a_first_apparent: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sel[0] == 3'h2 && mask[0] == 3'h1) |-> sum[0] == phase_power[0].apparent)
    else $error("first apparent source wrong");
  a_config_write_live: assert property (@(posedge sys_clk) disable iff (!resetn)
    (bus.wr && bus.addr == 4'h0) |=> st_ff.cfg == $past(bus.wdata))
    else $error("config write not applied");

  // ------------------------------
  // register port sequences
  // ------------------------------
  sequence s_cfg_write;
    bus.wr && bus.addr == `PSS_ADDR_CONFIG;
  endsequence

  sequence s_comp_write;
    bus.wr && bus.addr == `PSS_ADDR_COMP;
  endsequence

  sequence s_cfg_read;
    bus.rd && bus.addr == `PSS_ADDR_CONFIG;
  endsequence

  sequence s_no_read;
    !bus.rd;
  endsequence

  a_comp_write_live: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_comp_write |=> st_ff.comp == $past(bus.wdata))
    else $error("phase mask write not applied");

  a_cfg_kept_mask: assert property (@(posedge sys_clk) disable iff (!resetn)
    (s_comp_write and !s_cfg_write) |=> st_ff.cfg == $past(st_ff.cfg))
    else $error("mask write disturbed config");

  a_cfg_readback: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_cfg_read |=> rdata == $past(st_ff.cfg))
    else $error("config readback wrong");

  a_rdata_idle_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_no_read |=> rdata == `PSS_RD_ZERO)
    else $error("read data not zero when idle");

  a_status_readback: assert property (@(posedge sys_clk) disable iff (!resetn)
    (bus.rd && bus.addr == `PSS_ADDR_STATUS) |=> rdata == {13'h0000, $past(st_ff.pulse)})
    else $error("status readback wrong");

  a_second_total_act: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sel[1] == 3'h0 && mask[1] == 3'h2) |-> sum[1] == phase_power[1].tot_act)
    else $error("second total active source wrong");

  a_third_total_act: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sel[2] == 3'h0 && mask[2] == 3'h4) |-> sum[2] == phase_power[2].tot_act)
    else $error("third total active source wrong");

  a_first_fund_react: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sel[0] == 3'h4 && mask[0] == 3'h2) |-> sum[0] == phase_power[1].fund_react)
    else $error("first fundamental reactive source wrong");

  a_first_fund_act: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sel[0] == 3'h3 && mask[0] == 3'h4) |-> sum[0] == phase_power[2].fund_act)
    else $error("first fundamental active source wrong");

  a_second_fund_act: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sel[1] == 3'h3 && mask[1] == 3'h1) |-> sum[1] == phase_power[0].fund_act)
    else $error("second fundamental active source wrong");

  a_third_apparent: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sel[2] == 3'h2 && mask[2] == 3'h1) |-> sum[2] == phase_power[0].apparent)
    else $error("third apparent source wrong");

  a_third_reactive: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sel[2] == 3'h1 && mask[2] == 3'h2) |-> sum[2] == phase_power[1].tot_react)
    else $error("third reactive source wrong");

  a_first_total_act: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sel[0] == 3'h0 && mask[0] == 3'h4) |-> sum[0] == phase_power[2].tot_act)
    else $error("first total active source wrong");

  a_first_reactive: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sel[0] == 3'h1 && mask[0] == 3'h1) |-> sum[0] == phase_power[0].tot_react)
    else $error("first reactive source wrong");

  a_first_masked_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mask[0] == 3'h0) |-> sum[0] == 16'h0000)
    else $error("first sum not empty without phases");

  a_third_masked_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mask[2] == 3'h0) |-> sum[2] == 16'h0000)
    else $error("third sum not empty without phases");

  a_second_reserved_acc: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sel[1] > PSS_SRC_FUND_REACT) |=> st_ff.acc[1] == `PSS_ACC_ZERO)
    else $error("second accumulator runs on reserved code");

  a_first_reserved_acc: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sel[0] > PSS_SRC_FUND_REACT) |=> st_ff.acc[0] == `PSS_ACC_ZERO)
    else $error("first accumulator runs on reserved code");

  a_third_reserved_low: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sel[2] > PSS_SRC_FUND_REACT) |=> !third_pulse_out)
    else $error("third output active on reserved code");

  a_first_hold_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    (active[0] && !power_strobe) |=> $stable(first_pulse_out))
    else $error("first output moved without a sample");

  a_second_hold_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    (active[1] && !power_strobe) |=> $stable(second_pulse_out))
    else $error("second output moved without a sample");

  a_third_hold_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    (active[2] && !power_strobe) |=> $stable(third_pulse_out))
    else $error("third output moved without a sample");

  a_second_acc_step: assert property (@(posedge sys_clk) disable iff (!resetn)
    (active[1] && power_strobe) |=> st_ff.acc[1] == $past(acc_add[1][19:0]))
    else $error("second accumulator step wrong");

  a_third_acc_step: assert property (@(posedge sys_clk) disable iff (!resetn)
    (active[2] && power_strobe) |=> st_ff.acc[2] == $past(acc_add[2][19:0]))
    else $error("third accumulator step wrong");
endmodule
`default_nettype wire
